//--- testbench/host_model.sv
`timescale 1ns/1ns
`default_nettype none
module host_model (
    // clock and status
    input wire logic clk,
    input wire logic busy,
    // control pins
    output logic convert_start_n,
    output logic chip_select_n,
    output logic read_n
);
    int ready_cnt = 0;
    initial begin
        convert_start_n = 1'b1;
        chip_select_n = 1'b1;
        read_n = 1'b1;
    end
    // start stays high until asked, so a request is one clean falling edge
    task start(input bit hold);
        @(negedge clk) convert_start_n = 1'b0;
        if (!hold) @(negedge clk) convert_start_n = 1'b1;
    endtask
    task release_start;
        @(negedge clk) convert_start_n = 1'b1;
    endtask
    task bus(input logic cs, input logic rd);
        @(negedge clk);
        chip_select_n = cs;
        read_n = rd;
    endtask
    // busy falling taken as data ready, answered by one read strobe
    always @(negedge busy) begin
        ready_cnt++;
        bus(1'b0, 1'b0);
        bus(1'b1, 1'b1);
    end
endmodule
`default_nettype wire

//--- testbench/tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "conv_ctrl_cfg.svh"
module tb;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic reset_in = 1'b0;
    logic power_down_in = 1'b0;
    logic port_format_select = 1'b0;
    logic ext_sclk = 1'b0;
    logic [`DATA_W-1:0] core_result = 16'h0000;
    logic convert_start_n, chip_select_n, read_n;
    logic busy, low_power, parallel_oe, serial_oe, sclk_gated;
    logic [`DATA_W-1:0] result;
    int error_cnt = 0;
    int checks_done = 0;
    int seed = 32'h5c60;
    int n;
    int base;
    logic [3:0] v;
    initial begin
        forever #25 clk = ~clk;
    end
    host_model host (.clk(clk), .busy(busy), .convert_start_n(convert_start_n),
        .chip_select_n(chip_select_n), .read_n(read_n));
    conv_ctrl uut (.clk(clk), .nrst(nrst), .convert_start_n(convert_start_n),
        .chip_select_n(chip_select_n), .read_n(read_n), .reset_in(reset_in),
        .power_down_in(power_down_in), .port_format_select(port_format_select),
        .ext_sclk(ext_sclk), .core_result(core_result), .busy(busy), .low_power(low_power),
        .parallel_oe(parallel_oe), .serial_oe(serial_oe), .sclk_gated(sclk_gated), .result(result));
    task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // a driver is expected only with chip select and read low in the chosen format
    function automatic logic [15:0] exp_oe(input logic cs_n, input logic rd_n, input logic chosen);
        return 16'(!cs_n && !rd_n && chosen);
    endfunction
    task wait_busy(input logic lvl, input int lim);
        n = 0;
        while (busy !== lvl && n < lim) begin
            @(negedge clk);
            n++;
        end
    endtask
    task count_high;
        n = 0;
        while (busy === 1'b1 && n < 40) begin
            n++;
            @(negedge clk);
        end
    endtask
    task begin_conv;
        host.start(1'b1);
        wait_busy(1'b1, 4);
        check("busy rise", busy, 16'(1'b1));
    endtask
    task convert(input logic [15:0] code);
        core_result = code;
        begin_conv();
        fork
            host.release_start();
            count_high();
        join
        check("busy width", 16'(n), 16'(`CONV_CYCLES));
        check("result", result, code);
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        #(50 * 4000);
        error_cnt++;
        finish_test();
    end
    initial begin
        repeat (10) @(negedge clk);
        nrst = 1'b1;
        check("reset busy", busy, 16'h0000);
        check("reset result", result, 16'h0000);
        repeat (25) @(negedge clk);
        check("no edge no start", busy, 16'h0000);
        convert(16'ha5c3);
        $display("test edge start done");
        // start pulled low after busy falls and held through acquisition: level start at acquisition end
        host.start(1'b1);
        wait_busy(1'b1, 40);
        check("level start delay", 16'(n), 16'(`ACQ_CYCLES - 1));
        fork
            host.release_start();
            count_high();
        join
        check("level start width", 16'(n), 16'(`CONV_CYCLES));
        $display("test level start done");
        repeat (25) @(negedge clk);
        begin_conv();
        host.release_start();
        repeat (5) @(negedge clk);
        reset_in = 1'b1;
        @(negedge clk);
        reset_in = 1'b0;
        check("abort busy", busy, 16'h0000);
        check("abort result", result, 16'ha5c3);
        $display("test abort done");
        repeat (25) @(negedge clk);
        core_result = 16'h0ff1;
        begin_conv();
        power_down_in = 1'b1;
        fork
            host.release_start();
            count_high();
        join
        check("pd finish width", 16'(n), 16'(`CONV_CYCLES));
        check("pd result", result, 16'h0ff1);
        check("pd low power", low_power, 16'h0001);
        repeat (25) @(negedge clk);
        host.start(1'b0);
        repeat (5) @(negedge clk);
        check("pd refuses", busy, 16'h0000);
        power_down_in = 1'b0;
        $display("test power down done");
        repeat (25) @(negedge clk);
        base = host.ready_cnt;
        repeat (4) begin
            convert(16'($random(seed)));
            repeat (25) @(negedge clk);
        end
        check("ready strobes", 16'(host.ready_cnt - base), 16'h0004);
        $display("test random done");
        for (int i = 0; i < 16; i++) begin
            v = 4'(i);
            host.bus(v[3], v[2]);
            port_format_select = v[1];
            ext_sclk = v[0];
            #5;
            check("parallel oe", 16'(parallel_oe), exp_oe(v[3], v[2], !v[1]));
            check("serial oe", 16'(serial_oe), exp_oe(v[3], v[2], v[1]));
            check("sclk gate", 16'(sclk_gated), 16'(v[0] && !v[3] && v[1]));
        end
        host.bus(1'b1, 1'b1);
        $display("test bus enables done");
        finish_test();
    end
endmodule
`default_nettype wire

//--- verilog/conv_ctrl.sv
// Operation
// - busy rises at conversion start, falls once result sits in result register
// - output bus enabled only while chip select and read both low
// - external serial clock accepted only while chip select low
// - reset input high resets device and abandons any running conversion
// - power-down high blocks new conversions but finishes the current one
// - start high at acquisition end: wait, convert on its next falling edge
// - start already low at acquisition end: convert immediately
// - port format select low gives parallel bus, high gives serial pins
`timescale 1ns/1ns
`default_nettype none
`include "conv_ctrl_cfg.svh"

module conv_ctrl (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // host control pins
    input wire logic convert_start_n,
    input wire logic chip_select_n,
    input wire logic read_n,
    input wire logic reset_in,
    input wire logic power_down_in,
    input wire logic port_format_select,
    input wire logic ext_sclk,
    // converter core
    input wire logic [`DATA_W-1:0] core_result,
    // status and bus control
    output logic busy,
    output logic low_power,
    output logic parallel_oe,
    output logic serial_oe,
    output logic sclk_gated,
    output logic [`DATA_W-1:0] result
);
    import conv_ctrl_pkg::*;

    // ------------------------------------------------------------
    // conversion sequencer
    // ------------------------------------------------------------
    conv_state_t state_reg;
    conv_state_t state_next;
    logic start_d_reg;
    logic start_d_next;
    logic busy_reg;
    logic busy_next;
    logic [`DATA_W-1:0] result_reg;
    logic [`DATA_W-1:0] result_next;
    logic timer_load;
    logic timer_done;
    logic [`CNT_W-1:0] timer_value;
    logic start_fall;
    logic boot_reg;
    logic boot_next;
    logic acq_kick;

    assign start_fall = start_d_reg & ~convert_start_n;

    cycle_timer u_timer (
        .clk(clk),
        .nrst(nrst),
        .load(timer_load),
        .clear(reset_in),
        .load_value(timer_value),
        .done(timer_done)
    );

    always_comb begin
        state_next = state_reg;
        busy_next = busy_reg;
        result_next = result_reg;
        start_d_next = convert_start_n;
        timer_load = 1'b0;
        timer_value = `CNT_W'(`CONV_CYCLES);
        if (reset_in) begin
            // abandoned conversion leaves the old result untouched
            state_next = ST_ACQ;
            busy_next = 1'b0;
            timer_load = 1'b0;
        end else if (acq_kick) begin
            // acquisition is timed afresh, so a start right after reset is too early
            timer_load = 1'b1;
            timer_value = `CNT_W'(`ACQ_CYCLES);
        end else begin
            unique case (state_reg)
                ST_ACQ: begin
                    if (timer_done) begin
                        if (!convert_start_n && !power_down_in) begin
                            state_next = ST_CONV;
                            busy_next = 1'b1;
                            timer_load = 1'b1;
                        end else begin
                            state_next = ST_WAIT;
                        end
                    end
                end
                ST_WAIT: begin
                    // a held-low start does not count once waiting; only an edge starts
                    if (start_fall && !power_down_in) begin
                        state_next = ST_CONV;
                        busy_next = 1'b1;
                        timer_load = 1'b1;
                    end
                end
                ST_CONV: begin
                    // power-down is not looked at here, so a running conversion completes
                    if (timer_done) begin
                        result_next = core_result;
                        busy_next = 1'b0;
                        state_next = ST_ACQ;
                        timer_load = 1'b1;
                        timer_value = `CNT_W'(`ACQ_CYCLES);
                    end
                end
                default: begin
                    state_next = ST_ACQ;
                    busy_next = 1'b0;
                end
            endcase
        end
    end

    // acquisition timer is started at reset release by the first-cycle flag
    always_comb begin
        boot_next = 1'b0;
        if (reset_in) begin
            boot_next = 1'b1;
        end
    end

    assign acq_kick = boot_reg & ~reset_in;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= ST_ACQ;
            busy_reg <= 1'b0;
            result_reg <= `RESULT_RST;
            start_d_reg <= 1'b1;
            boot_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            busy_reg <= busy_next;
            result_reg <= result_next;
            start_d_reg <= start_d_next;
            boot_reg <= boot_next;
        end
    end

    // busy length is counted only so that the checks below can measure it
    logic [`CNT_W-1:0] busy_len_reg;
    logic [`CNT_W-1:0] busy_len_next;
    always_comb begin
        busy_len_next = '0;
        if (busy_reg) begin
            busy_len_next = busy_len_reg + `CNT_W'(1);
        end
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            busy_len_reg <= '0;
        end else begin
            busy_len_reg <= busy_len_next;
        end
    end

    // ------------------------------------------------------------
    // output bus and serial clock gating
    // ------------------------------------------------------------
    logic bus_enable;
    assign bus_enable = ~chip_select_n & ~read_n;
    assign parallel_oe = bus_enable & ~port_format_select;
    assign serial_oe = bus_enable & port_format_select;
    assign sclk_gated = ext_sclk & ~chip_select_n & port_format_select;
    assign busy = busy_reg;
    assign low_power = power_down_in & ~busy_reg;
    assign result = result_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_busy_rise_on_start;
        @(posedge clk) disable iff (!nrst)
        ($past(state_reg) != ST_CONV) && (state_reg == ST_CONV) |-> busy;
    endproperty
    a_busy_rise_on_start: assert property (p_busy_rise_on_start) else $error("busy low at start");

    property p_busy_len;
        @(posedge clk) disable iff (!nrst)
        $rose(busy) && !reset_in |-> busy [*2];
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy too short");

    property p_busy_width;
        @(posedge clk) disable iff (!nrst)
        $fell(busy) && !$past(reset_in) |-> busy_len_reg == `CNT_W'(`CONV_CYCLES);
    endproperty
    a_busy_width: assert property (p_busy_width) else $error("busy width wrong");

    property p_boot_acq;
        @(posedge clk) disable iff (!nrst)
        acq_kick |=> state_reg == ST_ACQ && !busy && !timer_done;
    endproperty
    a_boot_acq: assert property (p_boot_acq) else $error("no acquisition after reset");

    property p_bus_enable;
        @(posedge clk) disable iff (!nrst)
        (parallel_oe || serial_oe) |-> (!chip_select_n && !read_n);
    endproperty
    a_bus_enable: assert property (p_bus_enable) else $error("bus enabled without cs and rd");

    property p_sclk_gate;
        @(posedge clk) disable iff (!nrst)
        chip_select_n |-> !sclk_gated;
    endproperty
    a_sclk_gate: assert property (p_sclk_gate) else $error("sclk passed with cs high");

    property p_reset_abort;
        @(posedge clk) disable iff (!nrst)
        reset_in |=> !busy && $stable(result);
    endproperty
    a_reset_abort: assert property (p_reset_abort) else $error("reset did not abort");

    property p_pd_no_start;
        @(posedge clk) disable iff (!nrst)
        power_down_in && !busy |=> !busy;
    endproperty
    a_pd_no_start: assert property (p_pd_no_start) else $error("start during power-down");

    property p_edge_start;
        @(posedge clk) disable iff (!nrst)
        state_reg == ST_WAIT && start_fall && !power_down_in && !reset_in |=> busy;
    endproperty
    a_edge_start: assert property (p_edge_start) else $error("edge start missed");

    property p_wait_hold;
        @(posedge clk) disable iff (!nrst)
        state_reg == ST_WAIT && !start_fall |=> !busy;
    endproperty
    a_wait_hold: assert property (p_wait_hold) else $error("start without edge");

    property p_format;
        @(posedge clk) disable iff (!nrst)
        !(parallel_oe && serial_oe);
    endproperty
    a_format: assert property (p_format) else $error("both ports enabled");

    c_conv: cover property (@(posedge clk) disable iff (!nrst) $fell(busy));
    c_wait: cover property (@(posedge clk) disable iff (!nrst) state_reg == ST_WAIT ##1 busy);
    c_abort: cover property (@(posedge clk) disable iff (!nrst) busy ##1 reset_in);
endmodule
`default_nettype wire

//--- verilog/conv_ctrl_cfg.svh
`ifndef CONV_CTRL_CFG_SVH
`define CONV_CTRL_CFG_SVH

// acquisition time in ns and its cycle count at 20 MHz (least time, rounded up)
`define ACQ_TIME_NS 1000
`define CLK_PERIOD_NS 50
`define ACQ_CYCLES ((`ACQ_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// conversion time in ns and its cycle count
`define CONV_TIME_NS 1500
`define CONV_CYCLES ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W 8
`define DATA_W 16
`define SER_PINS 8
`define RESULT_RST 16'h0000

`endif

//--- verilog/conv_ctrl_pkg.sv
`default_nettype none
package conv_ctrl_pkg;
    typedef enum logic [1:0] {
        ST_ACQ = 2'b00,
        ST_WAIT = 2'b01,
        ST_CONV = 2'b11
    } conv_state_t;
endpackage
`default_nettype wire

//--- verilog/cycle_timer.sv
`timescale 1ns/1ns
`default_nettype none
`include "conv_ctrl_cfg.svh"

module cycle_timer (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // control
    input wire logic load,
    input wire logic clear,
    input wire logic [`CNT_W-1:0] load_value,
    // status
    output logic done
);
    logic [`CNT_W-1:0] count_reg;
    logic [`CNT_W-1:0] count_next;

    always_comb begin
        count_next = count_reg;
        if (clear) begin
            count_next = '0;
        end else if (load) begin
            count_next = load_value;
        end else if (count_reg != '0) begin
            count_next = count_reg - 8'h01;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end

    assign done = (count_reg == 8'h01);
endmodule
`default_nettype wire
